/* File: rtl/float_operand_format.sv */
// Operand-format datapath: fixed and float interpretation, pack, compare.
// Assumes main control issues one op at a time; storage may wait any number of cycles before ready.
`timescale 1ns/10ps
`default_nettype none
module float_operand_format #(
  parameter bit HAS_ARITH_OPTION = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire float_format_pkg::op_e op_i,
  input wire logic [float_format_pkg::ADDR_W-1:0] addr_i,
  input wire logic indirect_i,
  input wire logic [float_format_pkg::ADDR_W-1:0] index_i,
  input wire logic [float_format_pkg::WORD_W-1:0] mem_data_i,
  input wire logic mem_ready_i,
  input wire logic pack_sign_i,
  input wire logic signed [float_format_pkg::EXP_W:0] pack_exp_i,
  input wire logic [float_format_pkg::FRAC_W-1:0] pack_frac_i,
  input wire logic [float_format_pkg::WORD_W-1:0] fix_b_i,
  input wire logic exp_overflow_i,
  input wire logic exp_underflow_i,
  input wire logic divide_fault_i,
  input wire logic fault_sense_op_i,
  output logic mem_req_o,
  output logic [float_format_pkg::ADDR_W-1:0] mem_addr_o,
  output logic busy_o,
  output logic done_o,
  output logic trap_o,
  output logic [float_format_pkg::FLOAT_W-1:0] combined_word_o,
  output logic [float_format_pkg::FLOAT_W-1:0] ext_o,
  output logic [float_format_pkg::WORD_W-1:0] fix_result_o,
  output logic fix_neg_o,
  output logic [float_format_pkg::WORD_W-2:0] fix_mag_o,
  output logic cmp_less_o,
  output logic cmp_equal_o,
  output logic unp_valid_o,
  output logic unp_sign_o,
  output logic signed [float_format_pkg::EXP_W:0] unp_exp_o,
  output logic [float_format_pkg::FRAC_W-1:0] unp_frac_o,
  output logic unp_normal_o,
  output logic unp_zero_o,
  output logic [2:0] fault_flags_o
);
  import float_format_pkg::*;

  // One's-complement add with end-around carry, minus zero folded to plus
  function automatic logic [WORD_W-1:0] ones_add(input logic [WORD_W-1:0] a,
                                                 input logic [WORD_W-1:0] b);
    logic [WORD_W:0] s;
    logic [WORD_W-1:0] r;
    s = {1'b0, a} + {1'b0, b};
    r = s[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, s[WORD_W]};
    ones_add = (&r) ? '0 : r;  // RQ13
  endfunction

  // Signed ordering of one's-complement words, either zero treated alike
  function automatic logic ones_less(input logic [FLOAT_W-1:0] a,
                                     input logic [FLOAT_W-1:0] b);
    logic [FLOAT_W-1:0] ma;
    logic [FLOAT_W-1:0] mb;
    ma = a[FLT_SIGN_POS] ? ~a : a;
    mb = b[FLT_SIGN_POS] ? ~b : b;
    if (a[FLT_SIGN_POS] != b[FLT_SIGN_POS])
      ones_less = a[FLT_SIGN_POS] & ((ma | mb) != '0);
    else if (a[FLT_SIGN_POS])
      ones_less = ma > mb;
    else
      ones_less = ma < mb;
  endfunction

  fetch_state_e state;
  fetch_state_e next_state;
  op_e cur_op;
  logic [ADDR_W-1:0] eff_addr;
  logic [WORD_W-1:0] hi_word;
  logic [FLOAT_W-1:0] operand;
  logic operand_valid;
  logic [2:0] fault_latch;

  // Effective address: index added in one's complement, as other memory refs
  wire [WORD_W-1:0] addr_sum = ones_add({{(WORD_W-ADDR_W){1'b0}}, addr_i},
                                        {{(WORD_W-ADDR_W){1'b0}}, index_i});
  wire [ADDR_W-1:0] indexed_addr = addr_sum[ADDR_W-1:0];  // RQ12
  wire is_double = (op_i == OP_DMUL) || (op_i == OP_DDIV);
  wire needs_two = (cur_op == OP_FLOAT) || (cur_op == OP_LOAD)
                   || (cur_op == OP_COMPARE);
  wire take = start_i && (state == ST_IDLE);
  wire trap_now = take && is_double && !HAS_ARITH_OPTION;  // RQ3

  // Pack: exponent bias by sign of true exponent, minus zero never seen here
  wire exp_neg = pack_exp_i[EXP_W];
  wire [EXP_W:0] biased_ext = pack_exp_i + {1'b0, exp_neg ? BIAS_NEG : BIAS_POS};  // RQ8
  wire [EXP_W-1:0] pack_biased = biased_ext[EXP_W-1:0];  // RQ9
  wire pack_zero = pack_frac_i == '0;
  wire [FLOAT_W-1:0] pack_pos = {1'b0, pack_biased, pack_frac_i};  // RQ4 RQ7
  wire [FLOAT_W-1:0] packed_word =
    pack_zero ? FLOAT_RESET : (pack_sign_i ? ~pack_pos : pack_pos);  // RQ14 RQ13

  // Fixed word view: sign bit and 23-bit integer magnitude
  wire [WORD_W-1:0] fix_a = combined_word_o[FLOAT_W-1:WORD_W];
  wire fix_sign = fix_a[FIX_SIGN_POS];  // RQ1
  wire [WORD_W-1:0] fix_abs = fix_sign ? ~fix_a : fix_a;  // RQ2

  // Sequencer: indirect hop, then two consecutive storage words
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take && !trap_now && !is_double) begin
          if (op_i == OP_NONE || op_i == OP_PACK || op_i == OP_FIX_ADD)
            next_state = ST_DONE;
          else
            next_state = indirect_i ? ST_INDIRECT : ST_FETCH_HI;
        end else if (take && !trap_now) begin
          next_state = ST_DONE;
        end
      end
      ST_INDIRECT: next_state = mem_ready_i ? ST_FETCH_HI : ST_INDIRECT;
      ST_FETCH_HI: begin
        if (mem_ready_i)
          next_state = needs_two ? ST_FETCH_LO : ST_DONE;
      end
      ST_FETCH_LO: next_state = mem_ready_i ? ST_DONE : ST_FETCH_LO;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  assign mem_req_o = (state == ST_INDIRECT) || (state == ST_FETCH_HI)
                     || (state == ST_FETCH_LO);
  assign mem_addr_o = (state == ST_FETCH_LO) ? eff_addr + 15'h0001 : eff_addr;  // RQ11
  assign busy_o = state != ST_IDLE;
  assign done_o = state == ST_DONE;

  // State and operand capture
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cur_op <= OP_NONE;
      eff_addr <= ADDR_RESET;
      hi_word <= WORD_RESET;
      operand <= FLOAT_RESET;
      operand_valid <= 1'b0;
      trap_o <= 1'b0;
    end else begin
      state <= next_state;
      trap_o <= trap_now;  // RQ3
      operand_valid <= (state == ST_FETCH_LO) && mem_ready_i;
      if (take) begin
        cur_op <= op_i;
        eff_addr <= indexed_addr;  // RQ12
      end
      if (state == ST_INDIRECT && mem_ready_i)
        eff_addr <= mem_data_i[ADDR_W-1:0];  // RQ12
      if (state == ST_FETCH_HI && mem_ready_i)
        hi_word <= mem_data_i;
      if (state == ST_FETCH_LO && mem_ready_i)
        operand <= {hi_word, mem_data_i};  // RQ11
    end
  end

  // Joined accumulator, extension register and fixed-point result
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      combined_word_o <= FLOAT_RESET;
      ext_o <= FLOAT_RESET;
      fix_result_o <= WORD_RESET;
    end else begin
      if (take && op_i == OP_PACK)
        combined_word_o <= packed_word;  // RQ11
      if (state == ST_FETCH_LO && mem_ready_i && cur_op == OP_LOAD)
        combined_word_o <= {hi_word, mem_data_i};
      if (state == ST_FETCH_LO && mem_ready_i && cur_op == OP_FLOAT)
        ext_o <= {hi_word, mem_data_i};  // RQ11
      if (take && op_i == OP_FIX_ADD)
        fix_result_o <= ones_add(fix_a, fix_b_i);  // RQ13
    end
  end

  // Fixed view and float ordering through the plain fixed compare
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fix_neg_o <= 1'b0;
      fix_mag_o <= '0;
      cmp_less_o <= 1'b0;
      cmp_equal_o <= 1'b0;
    end else begin
      fix_neg_o <= fix_sign && (fix_abs != '0);  // RQ1
      fix_mag_o <= fix_abs[WORD_W-2:0];  // RQ2
      if (operand_valid && cur_op == OP_COMPARE) begin
        cmp_less_o <= ones_less(combined_word_o, operand);  // RQ10
        cmp_equal_o <= !ones_less(combined_word_o, operand)
                       && !ones_less(operand, combined_word_o);  // RQ10
      end
    end
  end

  // Faults stick until sensed; a new fault in the sensing cycle survives
  wire [2:0] fault_in = {divide_fault_i, exp_underflow_i, exp_overflow_i};
  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      fault_latch <= 3'h0;
    else
      fault_latch <= (fault_sense_op_i ? 3'h0 : fault_latch) | fault_in;  // RQ15
  end
  assign fault_flags_o = fault_latch;

  // Unpack of the most recent storage operand
  float_unpack u_unpack (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .valid_i(operand_valid),
    .word_i(operand),
    .valid_o(unp_valid_o),
    .sign_o(unp_sign_o),
    .exp_o(unp_exp_o),
    .frac_o(unp_frac_o),
    .normal_o(unp_normal_o),
    .zero_o(unp_zero_o)
  );  // RQ16
endmodule
`default_nettype wire

/* File: inc/float_format_pkg.sv */
// Shared constants and types for the operand-format datapath.
// Assumes a 24-bit one's-complement machine word and a 48-bit float word.
// Operation
// RQ1: Fixed word: top bit sign, 23-bit coefficient
// RQ2: Fixed operands are integers, point below bit 0
// RQ3: Double multiply/divide trap without arithmetic option
// RQ4: Fraction is 36 low bits of float
// RQ5: Fraction kept normalized, half up to one
// RQ6: Bit 47 is fraction sign, ones complement
// RQ7: Exponent field bits 46..36, biased, from zero
// RQ8: Bias 2000 octal non-negative, 1777 negative
// RQ9: Minus zero exponent uses 2000 bias
// RQ10: Biased floats order by plain fixed compare
// RQ11: Float uses joined accumulators, extension, two words
// RQ12: Float operand address takes indirect and index
// RQ13: Zero results delivered as positive zero
// RQ14: Negative float complements whole 48-bit word
// RQ15: Float faults latched, cleared by sensing
// RQ16: Unpack yields sign-magnitude fields in one cycle
package float_format_pkg;
  localparam int WORD_W = 24;
  localparam int FLOAT_W = 48;
  localparam int FRAC_W = 36;
  localparam int EXP_W = 11;
  localparam int ADDR_W = 15;
  localparam int FIX_SIGN_POS = 23;
  localparam int FLT_SIGN_POS = 47;
  localparam int EXP_LSB = 36;
  localparam int EXP_MSB = 46;
  localparam logic [EXP_W-1:0] BIAS_POS = 11'h400;  // Octal 2000
  localparam logic [EXP_W-1:0] BIAS_NEG = 11'h3FF;  // Octal 1777
  localparam logic [FLOAT_W-1:0] FLOAT_RESET = 48'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0;

  // Operation codes from the main control
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_LOAD = 4'h1,
    OP_PACK = 4'h2,
    OP_COMPARE = 4'h3,
    OP_FIX_ADD = 4'h4,
    OP_DMUL = 4'h5,
    OP_DDIV = 4'h6,
    OP_FLOAT = 4'h7
  } op_e;

  // Address fetch sequence, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_INDIRECT = 5'b00010,
    ST_FETCH_HI = 5'b00100,
    ST_FETCH_LO = 5'b01000,
    ST_DONE = 5'b10000
  } fetch_state_e;
endpackage

/* File: rtl/float_unpack.sv */
// Float unpack: splits a 48-bit float word into sign-magnitude fields.
// Assumes a registered input word; outputs are registered one cycle later.
`timescale 1ns/10ps
`default_nettype none
module float_unpack (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire logic [float_format_pkg::FLOAT_W-1:0] word_i,
  output logic valid_o,
  output logic sign_o,
  output logic signed [float_format_pkg::EXP_W:0] exp_o,
  output logic [float_format_pkg::FRAC_W-1:0] frac_o,
  output logic normal_o,
  output logic zero_o
);
  import float_format_pkg::*;

  // Complement a negative word whole, exponent included
  wire sign_bit = word_i[FLT_SIGN_POS];  // RQ6
  wire [FLOAT_W-1:0] mag_word = sign_bit ? ~word_i : word_i;  // RQ14
  wire [EXP_W-1:0] biased = mag_word[EXP_MSB:EXP_LSB];  // RQ7
  wire [FRAC_W-1:0] frac = mag_word[FRAC_W-1:0];  // RQ4
  // Remove whichever bias applies; field at or above 2000 is non-negative
  wire exp_pos = biased >= BIAS_POS;
  wire [EXP_W:0] exp_ext = {1'b0, biased};
  wire [EXP_W:0] pos_true = exp_ext - {1'b0, BIAS_POS};  // RQ8
  wire [EXP_W:0] neg_true = exp_ext - {1'b0, BIAS_NEG};  // RQ8
  wire frac_zero = frac == '0;

  // Single-cycle register of all fields
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      sign_o <= 1'b0;
      exp_o <= '0;
      frac_o <= '0;
      normal_o <= 1'b0;
      zero_o <= 1'b0;
    end else begin
      valid_o <= valid_i;  // RQ16
      sign_o <= sign_bit & ~frac_zero;  // RQ13
      exp_o <= exp_pos ? pos_true : neg_true;
      frac_o <= frac;
      normal_o <= frac[FRAC_W-1];  // RQ5
      zero_o <= frac_zero;
    end
  end
endmodule
`default_nettype wire

/* File: sim/float_operand_format_properties.sv */
// Checker for the operand-format datapath: timing and format relations.
// Assumes it is bound onto the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module float_operand_format_properties
  import float_format_pkg::*;
#(
  parameter bit HAS_ARITH_OPTION = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire float_format_pkg::op_e op_i,
  input wire logic exp_overflow_i,
  input wire logic fault_sense_op_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic trap_o,
  input wire logic [float_format_pkg::FLOAT_W-1:0] combined_word_o,
  input wire logic [float_format_pkg::WORD_W-1:0] fix_result_o,
  input wire logic fix_neg_o,
  input wire logic unp_valid_o,
  input wire logic [float_format_pkg::FRAC_W-1:0] unp_frac_o,
  input wire logic unp_normal_o,
  input wire logic unp_zero_o,
  input wire logic [2:0] fault_flags_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Pack needs no fetch, so it answers on the next cycle
  a_pack_done: assert property (start_i && !busy_o && op_i == OP_PACK |=> done_o)
    else $error("pack answer late");
  // Without the option a double op must trap and not be done on the next cycle
  a_double_trap: assert property (
    start_i && !busy_o && (op_i == OP_DMUL || op_i == OP_DDIV)
    |=> trap_o == !HAS_ARITH_OPTION && done_o == HAS_ARITH_OPTION)
    else $error("double op trap wrong");
  a_unpack_follows: assert property (unp_valid_o |-> $past(done_o))
    else $error("unpack not one cycle after done");
  a_zero_positive: assert property (fix_result_o != 24'hFFFFFF)
    else $error("minus zero result");
  // Minus zero in the upper word is not reported as negative
  a_sign_view: assert property (fix_neg_o ==
    $past(combined_word_o[47] && (combined_word_o[47:24] != 24'hFFFFFF)))
    else $error("sign view wrong");
  // Every non-zero operand the bench stores is normalized, so unpack must say so
  a_unpack_normal: assert property (
    unp_valid_o && !unp_zero_o |-> unp_normal_o && unp_frac_o[35])
    else $error("normal flag wrong");
  a_fault_latch: assert property (exp_overflow_i |=> fault_flags_o[0])
    else $error("fault not latched");
  a_fault_clear: assert property (fault_sense_op_i && !exp_overflow_i |=> !fault_flags_o[0])
    else $error("fault not cleared");
endmodule
bind float_operand_format float_operand_format_properties #(
  .HAS_ARITH_OPTION(HAS_ARITH_OPTION)
) chk_u (.*);
`default_nettype wire

/* File: sim/storage_model.sv */
// Storage model for the operand path: answers fetches from a small word array.
// Assumes the address holds until ready; slow mode adds one wait per word.
`timescale 1ns/10ps
`default_nettype none
module storage_model
  import float_format_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic mem_req_i,
  input wire logic [float_format_pkg::ADDR_W-1:0] mem_addr_i,
  output logic mem_ready_o,
  output logic [float_format_pkg::WORD_W-1:0] mem_data_o
);
  logic [WORD_W-1:0] mem [0:63];
  logic waited;
  // Ready is a same-cycle level; off-answer cycles show the inverse word
  assign mem_ready_o = mem_req_i && (!slow_i || waited);
  assign mem_data_o = mem_ready_o ? mem[mem_addr_i[5:0]] : ~mem[mem_addr_i[5:0]];
  // Toggle so every word of a pair waits once in slow mode
  always_ff @(posedge ref_clk_i) begin
    waited <= !rst_i && mem_req_i && !waited;
  end
endmodule
`default_nettype wire

/* File: sim/tb_float_operand_format.sv */
// Self-checking bench for the operand-format datapath.
// Assumes both arithmetic option settings and the storage model on the fetch path.
`timescale 1ns/10ps
`default_nettype none
module tb_float_operand_format;
  import float_format_pkg::*;
  logic ref_clk_i, rst_i, start_i, indirect_i, mem_ready_i, pack_sign_i, slow, uv;
  logic exp_overflow_i, exp_underflow_i, divide_fault_i, fault_sense_op_i, mem_req_o;
  logic busy_o, done_o, trap_o, fix_neg_o, cmp_less_o, cmp_equal_o;
  logic unp_valid_o, unp_sign_o, unp_normal_o, unp_zero_o;
  op_e op_i;
  logic [ADDR_W-1:0] addr_i, index_i, mem_addr_o;
  logic [WORD_W-1:0] mem_data_i, fix_b_i, fix_result_o;
  logic signed [EXP_W:0] pack_exp_i, unp_exp_o;
  logic [FRAC_W-1:0] pack_frac_i, unp_frac_o;
  logic [FLOAT_W-1:0] combined_word_o, ext_o;
  logic [WORD_W-2:0] fix_mag_o;
  logic trap_alt, done_alt;
  logic [2:0] fault_flags_o;
  int n_fail, total_checks;
  float_operand_format dut_u (.ext_o(ext_o), .fix_mag_o(fix_mag_o), .*);
  // Second copy without the arithmetic option, only to watch double ops trap
  float_operand_format #(.HAS_ARITH_OPTION(1'b0)) dut_trap_u (.trap_o(trap_alt),
    .done_o(done_alt), .mem_req_o(), .mem_addr_o(), .busy_o(), .combined_word_o(),
    .ext_o(), .fix_result_o(), .fix_neg_o(), .fix_mag_o(), .cmp_less_o(), .cmp_equal_o(),
    .unp_valid_o(), .unp_sign_o(), .unp_exp_o(), .unp_frac_o(), .unp_normal_o(),
    .unp_zero_o(), .fault_flags_o(), .*);
  storage_model mem_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .slow_i(slow),
    .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .mem_ready_o(mem_ready_i),
    .mem_data_o(mem_data_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Start one op, wait for done, then sample the cycle after it
  task automatic issue(input op_e op);
    int n;
    @(posedge ref_clk_i);
    start_i <= 1'b1;
    op_i <= op;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 30);
    chk("done", {47'h0, done_o}, 48'h1);
    @(negedge ref_clk_i);
    uv = unp_valid_o;
  endtask
  task automatic pack(input logic s, input logic signed [11:0] e, input logic [35:0] f,
      input logic [47:0] w, input logic [22:0] m);
    @(posedge ref_clk_i);
    pack_sign_i <= s;
    pack_exp_i <= e;
    pack_frac_i <= f;
    issue(OP_PACK);
    chk("packed", combined_word_o, w);
    @(negedge ref_clk_i);
    chk("sign view", {47'h0, fix_neg_o}, {47'h0, w[47]});
    chk("magnitude view", {25'h0, fix_mag_o}, {25'h0, m});
  endtask
  task automatic fix_add(input logic [23:0] b, input logic [23:0] r);
    @(posedge ref_clk_i);
    fix_b_i <= b;
    issue(OP_FIX_ADD);
    chk("fixed sum", {24'h0, fix_result_o}, {24'h0, r});
  endtask
  // Slow memory for direct fetches, prompt memory for indirect ones
  task automatic load(input logic [14:0] a, input logic [14:0] x, input logic ind,
      input logic [47:0] w, input logic signed [11:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    index_i <= x;
    indirect_i <= ind;
    slow <= ~ind;
    issue(OP_LOAD);
    chk("loaded", combined_word_o, w);
    chk("unpack valid", {47'h0, uv}, 48'h1);
    chk("unpack sign", {47'h0, unp_sign_o}, {47'h0, w[47]});
    chk("unpack exp", {36'h0, unp_exp_o}, {36'h0, e});
    chk("unpack frac", {12'h0, unp_frac_o}, 48'h800000000);
  endtask
  task automatic compare(input logic [14:0] a, input logic lt, input logic eq);
    @(posedge ref_clk_i);
    addr_i <= a;
    index_i <= 15'h0;
    indirect_i <= 1'b0;
    issue(OP_COMPARE);
    chk("compare", {46'h0, cmp_less_o, cmp_equal_o}, {46'h0, lt, eq});
  endtask
  // Fault pulses, then sense alone, then set and sense together
  task automatic faults(input logic [2:0] f, input logic s, input logic [2:0] exp);
    @(posedge ref_clk_i);
    {divide_fault_i, exp_underflow_i, exp_overflow_i} <= f;
    fault_sense_op_i <= s;
    @(posedge ref_clk_i);
    {divide_fault_i, exp_underflow_i, exp_overflow_i, fault_sense_op_i} <= 4'h0;
    @(negedge ref_clk_i);
    chk("faults", {45'h0, fault_flags_o}, {45'h0, exp});
  endtask
  // Float operand fetch lands in the extension register; slow storage here
  task automatic float_fetch(input logic [14:0] a, input logic [47:0] w, input logic z);
    @(posedge ref_clk_i);
    addr_i <= a;
    index_i <= 15'h0;
    indirect_i <= 1'b0;
    slow <= 1'b1;
    issue(OP_FLOAT);
    chk("extension", ext_o, w);
    chk("unpack valid", {47'h0, uv}, 48'h1);
    chk("unpack zero", {47'h0, unp_zero_o}, {47'h0, z});
    chk("unpack sign", {47'h0, unp_sign_o}, 48'h0);
  endtask
  // Double ops finish with the option and trap for one cycle without it
  task automatic double_op(input op_e op);
    @(posedge ref_clk_i);
    start_i <= 1'b1;
    op_i <= op;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    @(negedge ref_clk_i);
    chk("double done", {47'h0, done_o}, 48'h1);
    chk("double trap", {45'h0, trap_o, trap_alt, done_alt}, 48'h2);
    @(negedge ref_clk_i);
    chk("trap pulse", {46'h0, trap_alt, done_o}, 48'h0);
  endtask
  // Reset in mid-run clears faults and accumulator; a bare op is taken right after
  task automatic reset_mid();
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(negedge ref_clk_i);
    chk("reset faults", {45'h0, fault_flags_o}, 48'h0);
    chk("reset acc", combined_word_o, 48'h0);
    issue(OP_NONE);
  endtask
  initial begin
    {rst_i, start_i, indirect_i, pack_sign_i, slow, uv} = 6'b100000;
    {exp_overflow_i, exp_underflow_i, divide_fault_i, fault_sense_op_i} = 4'h0;
    {addr_i, index_i, fix_b_i, pack_exp_i, pack_frac_i} = '0;
    op_i = OP_NONE;
    for (int i = 0; i < 64; i++) begin
      mem_u.mem[i] = 24'h0;
    end
    {mem_u.mem[16], mem_u.mem[48], mem_u.mem[49]} = {24'h000030, 24'h3FC800, 24'h0};
    {mem_u.mem[34], mem_u.mem[35], mem_u.mem[36]} = {24'hBFC7FF, 24'hFFFFFF, 24'h403800};
    {mem_u.mem[38], mem_u.mem[39]} = {24'hFFFFFF, 24'hFFFFFF};
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    pack(1'b1, 12'sd3, 36'h800000000, 48'hBFC7FFFFFFFF, 23'h403800);
    pack(1'b0, -12'sd3, 36'h800000000, 48'h3FC800000000, 23'h3FC800);
    pack(1'b0, 12'sd0, 36'h800000000, 48'h400800000000, 23'h400800);
    pack(1'b0, 12'sd3, 36'h800000000, 48'h403800000000, 23'h403800);
    fix_add(24'hBFC7FF, 24'h000000);
    fix_add(24'h000001, 24'h403801);
    load(15'h20, 15'h02, 1'b0, 48'hBFC7FFFFFFFF, 12'sd3);
    load(15'h10, 15'h00, 1'b1, 48'h3FC800000000, -12'sd3);
    compare(15'h22, 1'b0, 1'b0);
    compare(15'h24, 1'b1, 1'b0);
    pack(1'b0, 12'sd0, 36'h0, 48'h0, 23'h0);
    compare(15'h26, 1'b0, 1'b1);
    float_fetch(15'h26, 48'hFFFFFFFFFFFF, 1'b1);
    float_fetch(15'h24, 48'h403800000000, 1'b0);
    double_op(OP_DMUL);
    double_op(OP_DDIV);
    faults(3'b111, 1'b0, 3'b111);
    faults(3'b000, 1'b1, 3'b000);
    faults(3'b001, 1'b1, 3'b001);
    pack(1'b1, 12'sd3, 36'h800000000, 48'hBFC7FFFFFFFF, 23'h403800);
    reset_mid();
    conclude();
  end
  // Whole run needs about 130 cycles
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
